// File: core/measure_channel.sv
`timescale 1ns/1ps
`default_nettype none
module measure_channel (
	input  wire logic                     ref_clk,
	input  wire logic                     resetn,
	input  wire logic                     restore,
	input  wire logic [7:0]               config_value,
	input  wire logic [7:0]               reference_value,
	input  wire wakeup_pkg::meas_result_s result,
	output logic                          triggered,
	output logic [7:0]                    average
);
	import wakeup_pkg::*;

	localparam int AW = 8 + AVG_FRAC;

	logic [3:0]      amplitude_delta_threshold;
	logic            include_triggering_sample;
	logic [1:0]      average_weight_select;
	logic            average_as_reference;
	logic [AW-1:0]   acc;
	logic [7:0]      compare_ref;
	logic            exceeds;
	logic [2:0]      shift;
	logic signed [AW+1:0] err;
	logic signed [AW+1:0] sum;
	logic [AW-1:0]   next_acc;

	function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
		abs_diff = (a > b) ? a - b : b - a;
	endfunction : abs_diff

	assign amplitude_delta_threshold = config_value[CFG_DELTA_LSB +: 4];
	assign include_triggering_sample = config_value[CFG_INCLUDE_BIT];
	assign average_weight_select     = config_value[CFG_WEIGHT_LSB +: 2];
	assign average_as_reference      = config_value[CFG_AVG_REF_BIT];
	assign average = acc[AW-1:AVG_FRAC];

	assign compare_ref = average_as_reference ? average : reference_value;
	assign exceeds = abs_diff(result.value, compare_ref) > {4'h0, amplitude_delta_threshold};

	// Weight 4/8/16/32 is a right shift of 2..5
	assign shift = 3'(WEIGHT_SHIFT_MIN) + {1'b0, average_weight_select};
	assign err = $signed({2'b00, result.value, AVG_FRAC'(0)}) - $signed({2'b00, acc});
	assign sum = $signed({2'b00, acc}) + (err >>> shift);
	assign next_acc = sum[AW-1:0];

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			triggered <= 1'b0;
		end else begin
			triggered <= result.done && exceeds;
		end
	end

	// Average carries fractional bits so small steps are not lost to truncation
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			acc <= '0;
		end else if (restore) begin
			acc <= '0;
		end else if (result.done && average_as_reference
			&& (!exceeds || include_triggering_sample)) begin
			acc <= next_acc;
		end
	end
endmodule : measure_channel
`default_nettype wire

// File: core/wakeup_pkg.sv
package wakeup_pkg;

	// Clock and wake-up timing
	localparam int CLK_HZ            = 20_000_000;
	localparam int STEP_LONG_MS      = 100;
	localparam int STEP_SHORT_MS     = 10;
	localparam int STEP_LONG_CYCLES  = STEP_LONG_MS * (CLK_HZ / 1000);
	localparam int STEP_SHORT_CYCLES = STEP_SHORT_MS * (CLK_HZ / 1000);

	// Register indices; the byte address is four times the index
	localparam int ADDR_W            = 12;
	localparam int IDX_WAKEUP_CTRL   = 'h31;
	localparam int IDX_AMP_CONFIG    = 'h32;
	localparam int IDX_AMP_REFERENCE = 'h33;
	localparam int IDX_AMP_AVERAGE   = 'h34;
	localparam int IDX_PH_CONFIG     = 'h36;
	localparam int IDX_PH_REFERENCE  = 'h37;
	localparam int IDX_CAP_CONFIG    = 'h3A;
	localparam int IDX_CAP_REFERENCE = 'h3B;
	localparam int IDX_AUX_STATUS    = 'h3C;
	localparam int IDX_IRQ_STATUS    = 'h40;
	localparam int IDX_IRQ_MASK      = 'h41;
	localparam int IDX_COMMAND       = 'h42;

	localparam logic [ADDR_W-1:0] ADDR_WAKEUP_CTRL   = ADDR_W'(IDX_WAKEUP_CTRL * 4);
	localparam logic [ADDR_W-1:0] ADDR_AMP_CONFIG    = ADDR_W'(IDX_AMP_CONFIG * 4);
	localparam logic [ADDR_W-1:0] ADDR_AMP_REFERENCE = ADDR_W'(IDX_AMP_REFERENCE * 4);
	localparam logic [ADDR_W-1:0] ADDR_AMP_AVERAGE   = ADDR_W'(IDX_AMP_AVERAGE * 4);
	localparam logic [ADDR_W-1:0] ADDR_PH_CONFIG     = ADDR_W'(IDX_PH_CONFIG * 4);
	localparam logic [ADDR_W-1:0] ADDR_PH_REFERENCE  = ADDR_W'(IDX_PH_REFERENCE * 4);
	localparam logic [ADDR_W-1:0] ADDR_CAP_CONFIG    = ADDR_W'(IDX_CAP_CONFIG * 4);
	localparam logic [ADDR_W-1:0] ADDR_CAP_REFERENCE = ADDR_W'(IDX_CAP_REFERENCE * 4);
	localparam logic [ADDR_W-1:0] ADDR_AUX_STATUS    = ADDR_W'(IDX_AUX_STATUS * 4);
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS    = ADDR_W'(IDX_IRQ_STATUS * 4);
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK      = ADDR_W'(IDX_IRQ_MASK * 4);
	localparam logic [ADDR_W-1:0] ADDR_COMMAND       = ADDR_W'(IDX_COMMAND * 4);

	localparam logic [7:0] REG_RESET = 8'h00;

	// Wake-up control fields
	localparam int WT_RANGE_BIT = 7;
	localparam int WT_CODE_LSB  = 4;
	localparam int WT_EVERY_BIT = 3;
	localparam int WT_AMP_BIT   = 2;
	localparam int WT_PH_BIT    = 1;
	localparam int WT_CAP_BIT   = 0;

	// Check configuration fields, same layout for every channel
	localparam int CFG_DELTA_LSB   = 4;
	localparam int CFG_INCLUDE_BIT = 3;
	localparam int CFG_WEIGHT_LSB  = 1;
	localparam int CFG_AVG_REF_BIT = 0;
	localparam int WEIGHT_SHIFT_MIN = 2;
	localparam int AVG_FRAC = 5;

	// Interrupt status and mask bits
	localparam int IRQ_TIMEOUT_BIT = 0;
	localparam int IRQ_AMP_BIT     = 1;
	localparam int IRQ_PH_BIT      = 2;
	localparam int IRQ_CAP_BIT     = 3;
	localparam int IRQ_W           = 4;

	localparam int CMD_RESTORE_BIT = 0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic channel_phase;
		logic field_detect;
		logic tx_active;
		logic osc_stable;
		logic rx_enabled;
		logic rx_receiving;
		logic peer_detect;
		logic collision_avoidance_active;
	} aux_state_s;

	typedef struct packed {
		logic       done;
		logic [7:0] value;
	} meas_result_s;

endpackage : wakeup_pkg

// File: core/wakeup_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module wakeup_tick_gen #(
	parameter int SHORT_CYCLES = 200_000,
	parameter int LONG_CYCLES  = 2_000_000
) (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       restart,
	input  wire logic       enable,
	input  wire logic       range_short,
	input  wire logic [2:0] timeout_code,
	output logic            tick
);
	localparam int PW = $clog2(LONG_CYCLES + 1);

	logic [PW-1:0] prescale;
	logic [PW-1:0] step_last;
	logic [2:0]    step;

	assign step_last = range_short ? PW'(SHORT_CYCLES - 1) : PW'(LONG_CYCLES - 1);

	// Period is (code + 1) whole base steps
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			prescale <= '0;
			step     <= 3'h0;
			tick     <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (restart || !enable) begin
				prescale <= '0;
				step     <= 3'h0;
			end else if (prescale == step_last) begin
				prescale <= '0;
				if (step == timeout_code) begin
					step <= 3'h0;
					tick <= 1'b1;
				end else begin
					step <= step + 3'h1;
				end
			end else begin
				prescale <= prescale + PW'(1);
			end
		end
	end
endmodule : wakeup_tick_gen
`default_nettype wire

// File: core/wakeup_timer_presence_detect.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Wake-up period is (code + 1) steps of 100 ms, or 10 ms with range set.
// - With every-timeout bit set, each timer expiry raises an interrupt.
// - Amplitude check bit runs amplitude measurement per timeout, interrupt beyond delta.
// - Phase check bit runs phase measurement per timeout, interrupt beyond delta.
// - Capacitance check bit runs capacitance measurement per timeout, interrupt beyond delta.
// - Amplitude config bits 7..4 hold the four-bit amplitude delta.
// - Config bit 3 decides whether a triggering sample enters the average.
// - Weight codes 00..11 select 4, 8, 16, 32 for the newest sample.
// - Config bit 0 compares against the running average, not the stored reference.
// - Eight-bit read-write amplitude reference register holds the comparison value.
// - Control, config and reference registers clear on reset and restore command.
// - Auxiliary status clears on reset and restore, then shows live state.
// - Status bit 7 shows selected channel: 0 amplitude, 1 phase.
// - Status bit 6 mirrors the external field detector output.
// - Status bit 5 is 1 while transmitting.
// - Status bit 4 is 1 once the crystal oscillator runs stable.
// - Status bit 3 shows decoder enabled, bit 2 decoder receiving.
// - Status bit 1 shows peer detection mode, bit 0 collision avoidance.
module wakeup_timer_presence_detect #(
	parameter int SHORT_STEP_CYCLES = wakeup_pkg::STEP_SHORT_CYCLES,
	parameter int LONG_STEP_CYCLES  = wakeup_pkg::STEP_LONG_CYCLES
) (
	input  wire logic                     ref_clk,
	input  wire logic                     resetn,
	input  wire logic [11:0]              s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [11:0]              s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	input  wire wakeup_pkg::aux_state_s   aux_state,
	input  wire wakeup_pkg::meas_result_s amp_result,
	input  wire wakeup_pkg::meas_result_s phase_result,
	input  wire wakeup_pkg::meas_result_s cap_result,
	output logic [2:0]                    meas_start,
	output logic                          irq
);
	import wakeup_pkg::*;

	logic [7:0]        wakeup_timer_control;
	logic [7:0]        amplitude_check_config;
	logic [7:0]        amplitude_reference;
	logic [7:0]        phase_check_config;
	logic [7:0]        phase_reference;
	logic [7:0]        cap_check_config;
	logic [7:0]        cap_reference;
	logic [7:0]        auxiliary_status;
	logic [IRQ_W-1:0]  irq_status;
	logic [IRQ_W-1:0]  irq_mask;
	logic [IRQ_W-1:0]  irq_set;
	logic [IRQ_W-1:0]  irq_clear;
	aux_state_s        aux_meta;
	aux_state_s        aux_sync;
	logic              restore;
	logic              timer_restart;
	logic              tick;
	logic [2:0]        waiting;
	logic [2:0]        check_enable;
	logic [2:0]        triggered;
	meas_result_s      amp_accept;
	meas_result_s      phase_accept;
	meas_result_s      cap_accept;
	logic [7:0]        amp_average;
	logic [7:0]        phase_average;
	logic [7:0]        cap_average;
	logic              aw_held;
	logic              w_held;
	logic [ADDR_W-1:0] wr_addr;
	logic [7:0]        wr_data;
	logic              wr_lane;
	logic              do_write;
	logic              wr_hit;
	logic              rd_hit;
	logic [7:0]        rd_value;

	function automatic logic is_write(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] target);
		is_write = (addr == target);
	endfunction : is_write

	assign check_enable = {wakeup_timer_control[WT_AMP_BIT], wakeup_timer_control[WT_PH_BIT],
		wakeup_timer_control[WT_CAP_BIT]};
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	// Live state crosses in from the transceiver through two flops
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			aux_meta <= '0;
			aux_sync <= '0;
		end else begin
			aux_meta <= aux_state;
			aux_sync <= aux_meta;
		end
	end

	// Bit order of the struct places each flag at its status position
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			auxiliary_status <= REG_RESET;
		end else if (restore) begin
			auxiliary_status <= REG_RESET;
		end else begin
			auxiliary_status <= aux_sync;
		end
	end

	// AXI write address and data are taken in either order
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			wr_addr       <= '0;
			wr_data       <= 8'h00;
			wr_lane       <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_held       <= 1'b1;
				wr_addr       <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_held       <= 1'b1;
				wr_data      <= s_axi_wdata[7:0];
				wr_lane      <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_comb begin
		wr_hit = 1'b1;
		unique case (wr_addr)
			ADDR_WAKEUP_CTRL, ADDR_AMP_CONFIG, ADDR_AMP_REFERENCE, ADDR_PH_CONFIG,
			ADDR_PH_REFERENCE, ADDR_CAP_CONFIG, ADDR_CAP_REFERENCE, ADDR_IRQ_STATUS,
			ADDR_IRQ_MASK, ADDR_COMMAND: wr_hit = 1'b1;
			ADDR_AMP_AVERAGE, ADDR_AUX_STATUS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Restore command takes effect the cycle after its write and wins over writes
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			restore       <= 1'b0;
			timer_restart <= 1'b0;
		end else begin
			restore <= do_write && wr_lane && is_write(wr_addr, ADDR_COMMAND)
				&& wr_data[CMD_RESTORE_BIT];
			timer_restart <= do_write && wr_lane && is_write(wr_addr, ADDR_WAKEUP_CTRL);
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wakeup_timer_control   <= REG_RESET;
			amplitude_check_config <= REG_RESET;
			amplitude_reference    <= REG_RESET;
			phase_check_config     <= REG_RESET;
			phase_reference        <= REG_RESET;
			cap_check_config       <= REG_RESET;
			cap_reference          <= REG_RESET;
		end else if (restore) begin
			wakeup_timer_control   <= REG_RESET;
			amplitude_check_config <= REG_RESET;
			amplitude_reference    <= REG_RESET;
			phase_check_config     <= REG_RESET;
			phase_reference        <= REG_RESET;
			cap_check_config       <= REG_RESET;
			cap_reference          <= REG_RESET;
		end else if (do_write && wr_lane) begin
			if (is_write(wr_addr, ADDR_WAKEUP_CTRL)) begin
				wakeup_timer_control <= wr_data;
			end
			if (is_write(wr_addr, ADDR_AMP_CONFIG)) begin
				amplitude_check_config <= wr_data;
			end
			if (is_write(wr_addr, ADDR_AMP_REFERENCE)) begin
				amplitude_reference <= wr_data;
			end
			if (is_write(wr_addr, ADDR_PH_CONFIG)) begin
				phase_check_config <= wr_data;
			end
			if (is_write(wr_addr, ADDR_PH_REFERENCE)) begin
				phase_reference <= wr_data;
			end
			if (is_write(wr_addr, ADDR_CAP_CONFIG)) begin
				cap_check_config <= wr_data;
			end
			if (is_write(wr_addr, ADDR_CAP_REFERENCE)) begin
				cap_reference <= wr_data;
			end
		end
	end

	wakeup_tick_gen #(
		.SHORT_CYCLES (SHORT_STEP_CYCLES),
		.LONG_CYCLES  (LONG_STEP_CYCLES)
	) u_tick (
		.ref_clk      (ref_clk),
		.resetn       (resetn),
		.restart      (timer_restart || restore),
		.enable       (wakeup_timer_control[WT_EVERY_BIT:0] != 4'h0),
		.range_short  (wakeup_timer_control[WT_RANGE_BIT]),
		.timeout_code (wakeup_timer_control[WT_CODE_LSB +: 3]),
		.tick         (tick)
	);

	// A channel still measuring skips the next timeout rather than queueing it
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			meas_start <= 3'h0;
			waiting    <= 3'h0;
		end else begin
			meas_start <= tick ? (check_enable & ~waiting) : 3'h0;
			waiting    <= (waiting | meas_start)
				& ~{amp_result.done, phase_result.done, cap_result.done};
		end
	end

	// Results only count while the matching measurement is outstanding
	assign amp_accept   = '{done: amp_result.done && waiting[2], value: amp_result.value};
	assign phase_accept = '{done: phase_result.done && waiting[1], value: phase_result.value};
	assign cap_accept   = '{done: cap_result.done && waiting[0], value: cap_result.value};

	measure_channel u_amp (
		.ref_clk         (ref_clk),
		.resetn          (resetn),
		.restore         (restore),
		.config_value    (amplitude_check_config),
		.reference_value (amplitude_reference),
		.result          (amp_accept),
		.triggered       (triggered[2]),
		.average         (amp_average)
	);

	measure_channel u_phase (
		.ref_clk         (ref_clk),
		.resetn          (resetn),
		.restore         (restore),
		.config_value    (phase_check_config),
		.reference_value (phase_reference),
		.result          (phase_accept),
		.triggered       (triggered[1]),
		.average         (phase_average)
	);

	measure_channel u_cap (
		.ref_clk         (ref_clk),
		.resetn          (resetn),
		.restore         (restore),
		.config_value    (cap_check_config),
		.reference_value (cap_reference),
		.result          (cap_accept),
		.triggered       (triggered[0]),
		.average         (cap_average)
	);

	always_comb begin
		irq_set = '0;
		irq_set[IRQ_TIMEOUT_BIT] = tick && wakeup_timer_control[WT_EVERY_BIT];
		irq_set[IRQ_AMP_BIT]     = triggered[2];
		irq_set[IRQ_PH_BIT]      = triggered[1];
		irq_set[IRQ_CAP_BIT]     = triggered[0];
		irq_clear = '0;
		if (do_write && wr_lane && is_write(wr_addr, ADDR_IRQ_STATUS)) begin
			irq_clear = wr_data[IRQ_W-1:0];
		end
	end

	// A new event in the clearing cycle survives the clear
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			irq_status <= '0;
			irq_mask   <= '0;
			irq        <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_set;
			if (do_write && wr_lane && is_write(wr_addr, ADDR_IRQ_MASK)) begin
				irq_mask <= wr_data[IRQ_W-1:0];
			end
			irq <= |(((irq_status & ~irq_clear) | irq_set) & irq_mask);
		end
	end

	always_comb begin
		rd_hit   = 1'b1;
		rd_value = 8'h00;
		unique case (s_axi_araddr)
			ADDR_WAKEUP_CTRL:   rd_value = wakeup_timer_control;
			ADDR_AMP_CONFIG:    rd_value = amplitude_check_config;
			ADDR_AMP_REFERENCE: rd_value = amplitude_reference;
			ADDR_AMP_AVERAGE:   rd_value = amp_average;
			ADDR_PH_CONFIG:     rd_value = phase_check_config;
			ADDR_PH_REFERENCE:  rd_value = phase_reference;
			ADDR_CAP_CONFIG:    rd_value = cap_check_config;
			ADDR_CAP_REFERENCE: rd_value = cap_reference;
			ADDR_AUX_STATUS:    rd_value = auxiliary_status;
			ADDR_IRQ_STATUS:    rd_value = {4'h0, irq_status};
			ADDR_IRQ_MASK:      rd_value = {4'h0, irq_mask};
			ADDR_COMMAND:       rd_value = 8'h00;
			default:            rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= {24'h000000, rd_value};
				s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule : wakeup_timer_presence_detect
`default_nettype wire

// File: tb/test_wakeup_timer_presence_detect.sv
`timescale 1ns/1ps
`default_nettype none
module test_wakeup_timer_presence_detect;
	import wakeup_pkg::*;
	typedef struct packed {
		logic [11:0] a;
		logic [7:0]  d;
		logic [7:0]  q;
		logic [1:0]  r;
	} row_s;
	logic         ref_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic         s_axi_rvalid, s_axi_rready, irq;
	logic [11:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0]  s_axi_wdata, s_axi_rdata, q;
	logic [1:0]   s_axi_bresp, s_axi_rresp, r;
	logic [2:0]   meas_start;
	aux_state_s   aux_state;
	meas_result_s amp_result, phase_result, cap_result;
	int           mismatches, n_checks, cyc, n;
	row_s rows [5] = '{'{ADDR_WAKEUP_CTRL, 8'h70, 8'h70, RESP_OKAY},
		'{ADDR_AMP_CONFIG, 8'hA5, 8'hA5, RESP_OKAY}, '{ADDR_AMP_REFERENCE, 8'h5A, 8'h5A, RESP_OKAY},
		'{ADDR_COMMAND, 8'h00, 8'h00, RESP_OKAY}, '{12'hFFC, 8'hFF, 8'h00, RESP_SLVERR}};
	// Short steps keep a full wake-up period within a few dozen cycles
	wakeup_timer_presence_detect #(.SHORT_STEP_CYCLES(20), .LONG_STEP_CYCLES(50)) dut (.*,
		.s_axi_wstrb(4'hF));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_sim
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", s, e, g);
			mismatches++;
		end
	endtask : chk
	// Each bus task starts on a fresh edge so back-to-back calls never re-drive in one step
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		q = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic meas(input logic [7:0] v);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!meas_start[2] && n < 500);
		amp_result <= {1'b1, v};
		@(posedge ref_clk);
		amp_result <= 9'h000;
	endtask : meas
	task automatic run_one(input logic [7:0] v);
		wr(ADDR_WAKEUP_CTRL, 8'h84);
		meas(v);
		wr(ADDR_WAKEUP_CTRL, 8'h00);
	endtask : run_one
	// Phase and capacitance share one short timeout so both answer in the same cycle
	task automatic meas_pc(input logic [7:0] pv, input logic [7:0] cv);
		wr(ADDR_WAKEUP_CTRL, 8'h83);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (meas_start[1:0] != 2'h3 && n < 500);
		phase_result <= {1'b1, pv};
		cap_result <= {1'b1, cv};
		@(posedge ref_clk);
		phase_result <= 9'h000;
		cap_result <= 9'h000;
		wr(ADDR_WAKEUP_CTRL, 8'h00);
	endtask : meas_pc
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	initial begin
		{resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, aux_state, amp_result} = '0;
		{phase_result, cap_result} = '0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(ADDR_AUX_STATUS);
		chk("aux reset", 32'h0, q);
		foreach (rows[i]) begin
			rd(rows[i].a);
			chk("reset value", 32'h0, q);
		end
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			chk("bresp", rows[i].r, r);
			rd(rows[i].a);
			chk("rdata", rows[i].q, q);
			chk("rresp", rows[i].r, r);
		end
		for (int i = 0; i < 8; i++) begin
			aux_state <= aux_state_s'(8'h01 << i);
			repeat (4) @(posedge ref_clk);
			rd(ADDR_AUX_STATUS);
			chk("aux live", 32'h1 << i, q);
		end
		wr(ADDR_IRQ_MASK, 8'h0F);
		wr(ADDR_AMP_CONFIG, 8'h20);
		wr(ADDR_AMP_REFERENCE, 8'h50);
		wr(ADDR_WAKEUP_CTRL, 8'hA4);
		meas(8'h52);
		meas(8'h4E);
		chk("period", 32'd60, n + 1);
		repeat (4) @(posedge ref_clk);
		chk("irq within delta", 32'h0, irq);
		meas(8'h53);
		repeat (4) @(posedge ref_clk);
		chk("irq beyond delta", 32'h1, irq);
		wr(ADDR_WAKEUP_CTRL, 8'h08);
		rd(ADDR_IRQ_STATUS);
		chk("amp status", 32'h2, q);
		wr(ADDR_IRQ_STATUS, 8'h02);
		rd(ADDR_IRQ_STATUS);
		chk("status cleared", 32'h0, q);
		chk("irq cleared", 32'h0, irq);
		n = 0;
		while (!irq && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		rd(ADDR_IRQ_STATUS);
		chk("timeout status", 32'h1, q);
		wr(ADDR_IRQ_MASK, 8'h00);
		// The mask lands at the response edge; irq follows one edge later
		repeat (2) @(posedge ref_clk);
		chk("irq masked", 32'h0, irq);
		wr(ADDR_AMP_CONFIG, 8'hF1);
		run_one(8'h40);
		rd(ADDR_AMP_AVERAGE);
		chk("avg excluded", 32'h0, q);
		wr(ADDR_AMP_CONFIG, 8'hF9);
		run_one(8'h40);
		rd(ADDR_AMP_AVERAGE);
		chk("avg weight 4", 32'h10, q);
		wr(ADDR_IRQ_STATUS, 8'h0F);
		run_one(8'h18);
		rd(ADDR_IRQ_STATUS);
		chk("avg as ref", 32'h0, q);
		wr(ADDR_AMP_CONFIG, 8'hFF);
		run_one(8'h32);
		rd(ADDR_AMP_AVERAGE);
		chk("avg weight 32", 32'h13, q);
		wr(ADDR_IRQ_STATUS, 8'h0F);
		wr(ADDR_PH_CONFIG, 8'h30);
		wr(ADDR_PH_REFERENCE, 8'h20);
		wr(ADDR_CAP_CONFIG, 8'h10);
		wr(ADDR_CAP_REFERENCE, 8'h80);
		meas_pc(8'h24, 8'h81);
		rd(ADDR_IRQ_STATUS);
		chk("phase beyond delta", 32'h4, q);
		wr(ADDR_IRQ_STATUS, 8'h0F);
		meas_pc(8'h22, 8'h82);
		rd(ADDR_IRQ_STATUS);
		chk("cap beyond delta", 32'h8, q);
		wr(ADDR_COMMAND, 8'h01);
		rd(ADDR_AMP_CONFIG);
		chk("restore config", 32'h0, q);
		rd(ADDR_AMP_REFERENCE);
		chk("restore ref", 32'h0, q);
		wr(ADDR_AMP_REFERENCE, 8'h33);
		resetn <= 1'b0;
		@(posedge ref_clk);
		resetn <= 1'b1;
		rd(ADDR_AMP_REFERENCE);
		chk("reset ref", 32'h0, q);
		end_sim();
	end
endmodule : test_wakeup_timer_presence_detect
`default_nettype wire

// File: tb/wakeup_timer_presence_detect_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module wakeup_asserts (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	input  wire logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [2:0]  meas_start,
	input  wire logic        irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence start_seen;
		meas_start != 3'h0;
	endsequence
	AST_WR_ANSWER: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address open during response");
	AST_START_PULSE: assert property (start_seen |=> (meas_start == 3'h0) [*8])
		else $error("measurement start too long or too soon");
	AST_IRQ_RESET: assert property ($rose(resetn) |-> !irq)
		else $error("interrupt high out of reset");
endmodule : wakeup_asserts
bind wakeup_timer_presence_detect wakeup_asserts u_chk (.*);
`default_nettype wire
